// File: rtl/fas_top.v
// Flash access guard: ID check, stop control, boot area select and rewrite mode tracking.
`timescale 1ns/100ps
`include "fas_consts.vh"

module fas_top (
    input wire core_clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire processor_mode_pin,
    input wire erase_program_strap_n,
    input wire chip_enable_pin,
    input wire boot_strap_low_pin,
    input wire boot_strap_high_pin,
    input wire parallel_mode_pin,
    input wire wait_mode,
    input wire stop_mode,
    input wire flash_ready_flag,
    input wire [31:0] reset_vector,
    input wire [55:0] stored_id,
    input wire id_restart,
    input wire id_byte_valid,
    input wire [7:0] id_byte,
    output reg prog_cmd_enable,
    output reg flash_power_on,
    output reg flash_access_en,
    output reg flash_ctrl_init,
    output reg map_user_area,
    output reg user_area_prog_en,
    output reg boot_area_prog_en,
    output reg [2:0] rewrite_mode,
    output reg boot_mode
);

    // Two-stage synchronisers for the strap pins.
    reg [5:0] pin_meta_ff;
    reg [5:0] pin_sync_ff;

    reg [1:0] strap_cnt_ff;
    reg strap_taken_ff;
    reg boot_ff;
    reg parallel_ff;

    reg rw_en_ff;
    reg halt_ff;
    reg user_sel_ff;
    reg in_flash_ff;
    reg async_ff;
    reg halt_eff_prev_ff;
    reg sw_restart_ff;

    // Internal copy of the wait flag, so the handshake never reads back an output port.
    reg wait_ff;

    wire id_match;
    wire id_done;
    wire req;
    wire wr_take;
    wire halt_eff;
    wire low_power;
    wire id_bypass;
    wire serial_mode;
    wire cmd_ok;
    wire [2:0] mode_code;
    wire boot_entry;

    reg nxt_rw_en;
    reg nxt_halt;
    reg nxt_user_sel;
    reg nxt_in_flash;
    reg nxt_async;
    reg nxt_sw_restart;
    reg [31:0] nxt_rdata;

    function [31:0] status_word;
        input boot_v;
        input [2:0] mode_v;
        input match_v;
        input bypass_v;
        input cmd_v;
        input power_v;
        input access_v;
        input done_v;
        begin
            status_word = 32'h0;
            status_word[`FAS_STAT_BOOT] = boot_v;
            status_word[`FAS_STAT_MODE_LO +: 3] = mode_v;
            status_word[`FAS_STAT_MATCH] = match_v;
            status_word[`FAS_STAT_BYPASS] = bypass_v;
            status_word[`FAS_STAT_CMD_EN] = cmd_v;
            status_word[`FAS_STAT_POWER] = power_v;
            status_word[`FAS_STAT_ACCESS] = access_v;
            status_word[`FAS_STAT_ID_DONE] = done_v;
        end
    endfunction

    always @(posedge core_clk) begin
        if (sys_rst) begin
            pin_meta_ff <= 6'h0;
            pin_sync_ff <= 6'h0;
        end else begin
            pin_meta_ff <= {parallel_mode_pin, boot_strap_high_pin, boot_strap_low_pin,
                            chip_enable_pin, erase_program_strap_n, processor_mode_pin};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Boot entry needs processor mode high, erase strap low, chip enable high
    // and either boot strap in its selecting level.
    assign boot_entry = pin_sync_ff[0] && !pin_sync_ff[1] && pin_sync_ff[2]
                        && (!pin_sync_ff[3] || pin_sync_ff[4]);

    // Straps are caught once, after the synchronisers have filled following reset.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            strap_cnt_ff <= 2'h0;
            strap_taken_ff <= 1'b0;
            boot_ff <= 1'b0;
            parallel_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            if (strap_cnt_ff == `FAS_STRAP_WAIT) begin
                strap_taken_ff <= 1'b1;
                boot_ff <= boot_entry;
                parallel_ff <= pin_sync_ff[5] && !boot_entry;
            end else begin
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            end
        end
    end

    // The halt bit is stored regardless, but only acts with rewrite enabled.
    // A halt left set while rewrite was off reinitialises once rewrite is enabled.
    assign halt_eff = halt_ff && rw_en_ff;
    assign low_power = wait_mode || stop_mode;
    assign id_bypass = (reset_vector == `FAS_RV_ERASED);
    assign serial_mode = boot_ff && !user_sel_ff;
    // Other rewrite modes are never gated by the ID comparison.
    assign cmd_ok = !serial_mode || id_bypass || id_match;

    // Serial and parallel modes come from the straps; CPU rewrite from the enable bit.
    assign mode_code = parallel_ff ? `FAS_RWM_PARALLEL :
                       serial_mode ? (async_ff ? `FAS_RWM_SER_ASYNC : `FAS_RWM_SER_SYNC) :
                       rw_en_ff ? (in_flash_ff ? `FAS_RWM_CPU_FLASH : `FAS_RWM_CPU_EXT) :
                       `FAS_RWM_NONE;

    fas_id_cmp u_id_cmp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(id_restart || sw_restart_ff),
        .byte_valid(id_byte_valid && serial_mode),
        .byte_data(id_byte),
        .stored_id(stored_id),
        .match_ff(id_match),
        .done_ff(id_done)
    );

    // Avalon slave: one wait cycle, then the access completes.
    // Read data is captured while waitrequest is still high, so it already stands
    // at the edge where the master first sees waitrequest low.
    assign req = avs_read || avs_write;
    assign wr_take = avs_write && !wait_ff;

    always @* begin
        nxt_rw_en = rw_en_ff;
        nxt_halt = halt_ff;
        nxt_user_sel = user_sel_ff;
        nxt_in_flash = in_flash_ff;
        nxt_async = async_ff;
        nxt_sw_restart = 1'b0;
        if (wr_take) begin
            case (avs_address)
                `FAS_OFS_CTRL: begin
                    nxt_rw_en = avs_writedata[`FAS_CTRL_RW_EN];
                    nxt_halt = avs_writedata[`FAS_CTRL_HALT];
                    // Area select only exists in boot mode and is sticky once set.
                    if (boot_ff && avs_writedata[`FAS_CTRL_USER]) begin
                        nxt_user_sel = 1'b1;
                    end
                end
                `FAS_OFS_MODE: begin
                    nxt_in_flash = avs_writedata[`FAS_MODE_IN_FLASH];
                    nxt_async = avs_writedata[`FAS_MODE_ASYNC];
                end
                `FAS_OFS_IDC: begin
                    nxt_sw_restart = avs_writedata[`FAS_IDC_RESTART];
                end
                default: begin
                    nxt_sw_restart = 1'b0;
                end
            endcase
        end
    end

    always @* begin
        nxt_rdata = 32'h0;
        case (avs_address)
            `FAS_OFS_CTRL: begin
                nxt_rdata[`FAS_CTRL_READY] = flash_ready_flag;
                nxt_rdata[`FAS_CTRL_RW_EN] = rw_en_ff;
                nxt_rdata[`FAS_CTRL_HALT] = halt_ff;
                nxt_rdata[`FAS_CTRL_USER] = user_sel_ff;
            end
            `FAS_OFS_MODE: begin
                nxt_rdata[`FAS_MODE_IN_FLASH] = in_flash_ff;
                nxt_rdata[`FAS_MODE_ASYNC] = async_ff;
            end
            `FAS_OFS_STAT: begin
                nxt_rdata = status_word(boot_ff, mode_code, id_match, id_bypass, cmd_ok,
                                        flash_power_on, flash_access_en, id_done);
            end
            default: begin
                nxt_rdata = 32'h0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            wait_ff <= `FAS_RST_WAIT;
            avs_waitrequest <= `FAS_RST_WAIT;
            avs_readdata <= 32'h0;
        end else begin
            wait_ff <= !(req && wait_ff);
            avs_waitrequest <= !(req && wait_ff);
            if (avs_read && wait_ff) begin
                avs_readdata <= nxt_rdata;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            rw_en_ff <= `FAS_RST_CTRL;
            halt_ff <= `FAS_RST_CTRL;
            user_sel_ff <= `FAS_RST_CTRL;
            in_flash_ff <= `FAS_RST_MODE;
            async_ff <= `FAS_RST_MODE;
            sw_restart_ff <= 1'b0;
            halt_eff_prev_ff <= 1'b0;
        end else begin
            rw_en_ff <= nxt_rw_en;
            halt_ff <= nxt_halt;
            user_sel_ff <= nxt_user_sel;
            in_flash_ff <= nxt_in_flash;
            async_ff <= nxt_async;
            sw_restart_ff <= nxt_sw_restart;
            halt_eff_prev_ff <= halt_eff;
        end
    end

    // Outputs are all registered, so they lag their causes by one cycle.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            prog_cmd_enable <= 1'b0;
            flash_power_on <= 1'b0;
            flash_access_en <= 1'b0;
            flash_ctrl_init <= 1'b0;
            map_user_area <= 1'b0;
            user_area_prog_en <= 1'b0;
            boot_area_prog_en <= 1'b0;
            rewrite_mode <= `FAS_RWM_NONE;
            boot_mode <= 1'b0;
        end else begin
            prog_cmd_enable <= strap_taken_ff && cmd_ok && !halt_eff;
            flash_power_on <= !halt_eff && !low_power;
            flash_access_en <= strap_taken_ff && !halt_eff && !low_power;
            flash_ctrl_init <= halt_eff && !halt_eff_prev_ff;
            map_user_area <= strap_taken_ff && (!boot_ff || user_sel_ff);
            user_area_prog_en <= strap_taken_ff && (mode_code != `FAS_RWM_NONE)
                                 && !halt_eff && !low_power;
            boot_area_prog_en <= parallel_ff && !halt_eff && !low_power;
            rewrite_mode <= mode_code;
            boot_mode <= boot_ff;
        end
    end

endmodule // fas_top

// File: rtl/fas_consts.vh
// Constants for the flash access guard and stop block.
`ifndef FAS_CONSTS_VH
`define FAS_CONSTS_VH

// Register byte offsets on the Avalon-MM slave.
`define FAS_OFS_CTRL 4'h0
`define FAS_OFS_MODE 4'h4
`define FAS_OFS_STAT 4'h8
`define FAS_OFS_IDC 4'hC

// Control register bit positions.
`define FAS_CTRL_READY 0
`define FAS_CTRL_RW_EN 1
`define FAS_CTRL_HALT 3
`define FAS_CTRL_USER 5

// Mode register bit positions.
`define FAS_MODE_IN_FLASH 0
`define FAS_MODE_ASYNC 1

// Identification control register bit positions.
`define FAS_IDC_RESTART 0

// Status register bit positions.
`define FAS_STAT_BOOT 0
`define FAS_STAT_MODE_LO 1
`define FAS_STAT_MATCH 4
`define FAS_STAT_BYPASS 5
`define FAS_STAT_CMD_EN 6
`define FAS_STAT_POWER 7
`define FAS_STAT_ACCESS 8
`define FAS_STAT_ID_DONE 9

// Reset values.
`define FAS_RST_CTRL 1'h0
`define FAS_RST_MODE 1'h0
`define FAS_RST_WAIT 1'h1

// Rewrite mode codes.
`define FAS_RWM_NONE 3'h0
`define FAS_RWM_CPU_EXT 3'h1
`define FAS_RWM_CPU_FLASH 3'h2
`define FAS_RWM_SER_SYNC 3'h3
`define FAS_RWM_SER_ASYNC 3'h4
`define FAS_RWM_PARALLEL 3'h5

// Identification code length and erased reset vector.
`define FAS_ID_LEN 4'h7
`define FAS_ID_LAST 3'h6
`define FAS_RV_ERASED 32'hFFFFFFFF

// Cycles after reset release before straps are sampled (synchroniser depth).
`define FAS_STRAP_WAIT 2'h2

`endif

// File: rtl/fas_id_cmp.v
// Identification code comparator for the serial programmer.
`timescale 1ns/100ps
`include "fas_consts.vh"

module fas_id_cmp (
    input wire core_clk,
    input wire sys_rst,
    input wire restart,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire [55:0] stored_id,
    output reg match_ff,
    output reg done_ff
);

    reg [2:0] idx_ff;
    reg [2:0] nxt_idx;
    reg miss_ff;
    reg nxt_miss;
    reg nxt_match;
    reg nxt_done;
    wire [7:0] want;

    // Byte 0 sits in the low lane and is expected first.
    assign want = stored_id[idx_ff*8 +: 8];

    always @* begin
        nxt_idx = idx_ff;
        nxt_miss = miss_ff;
        nxt_match = match_ff;
        nxt_done = done_ff;
        if (restart) begin
            nxt_idx = 3'h0;
            nxt_miss = 1'b0;
            nxt_match = 1'b0;
            nxt_done = 1'b0;
        end
        // A byte arriving with a restart is checked at the old index, and is dropped if done is already set.
        if (byte_valid && !done_ff) begin
            if (byte_data != want) begin
                nxt_miss = 1'b1;
            end
            if (idx_ff == `FAS_ID_LAST) begin
                nxt_done = 1'b1;
                nxt_match = !(miss_ff || byte_data != want);
                nxt_idx = 3'h0;
            end else begin
                nxt_idx = idx_ff + 3'h1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            idx_ff <= 3'h0;
            miss_ff <= 1'b0;
            match_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            idx_ff <= nxt_idx;
            miss_ff <= nxt_miss;
            match_ff <= nxt_match;
            done_ff <= nxt_done;
        end
    end

endmodule // fas_id_cmp

// File: sim/fas_properties.sv
// Port-level assertions for the flash access guard block.
`timescale 1ns/100ps
module fas_properties (
    input wire core_clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire wait_mode,
    input wire stop_mode,
    input wire flash_power_on,
    input wire flash_ctrl_init,
    input wire map_user_area,
    input wire user_area_prog_en,
    input wire boot_area_prog_en,
    input wire [2:0] rewrite_mode,
    input wire boot_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answers: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8, 4'hC})
        |=> avs_readdata == 32'h0) else $error("unmapped read returned data");
    a_init_pulse: assert property (flash_ctrl_init |=> !flash_ctrl_init)
        else $error("init pulse longer than one cycle");
    a_sleep_powers_down: assert property ($rose(wait_mode || stop_mode) |-> ##[1:2] !flash_power_on)
        else $error("array still powered in wait or stop");
    a_boot_prog_parallel: assert property (boot_area_prog_en |-> rewrite_mode == 3'h5)
        else $error("boot area writable outside parallel mode");
    a_user_prog_mode: assert property (user_area_prog_en |-> rewrite_mode != 3'h0)
        else $error("user area writable with no rewrite mode");
    a_serial_in_boot: assert property (rewrite_mode inside {3'h3, 3'h4} |-> boot_mode && !$past(map_user_area))
        else $error("serial mode outside boot area mapping");
    a_user_map_holds: assert property (!$fell(map_user_area))
        else $error("user area mapping cleared");
endmodule // fas_properties

bind fas_top fas_properties u_fas_properties (.*);

// File: sim/fas_prog_model.sv
// Serial programmer model that sends a seven byte identification code.
`timescale 1ns/100ps
module fas_prog_model (
    input wire core_clk,
    input wire go,
    input wire [55:0] code,
    output logic id_byte_valid,
    output logic [7:0] id_byte
);
    int idx = 7;
    initial begin
        id_byte_valid = 1'h0;
        id_byte = 8'h00;
    end
    // Idle bytes toggle so a stale byte can never pass for a real one.
    always @(posedge core_clk) begin
        if (go) begin
            idx <= 0;
            id_byte_valid <= 1'h0;
        end else if (idx < 7) begin
            id_byte_valid <= 1'h1;
            id_byte <= code[idx*8 +: 8];
            idx <= idx + 1;
        end else begin
            id_byte_valid <= 1'h0;
            id_byte <= ~id_byte;
        end
    end
endmodule // fas_prog_model

// File: sim/fas_top_tb.sv
// Self-checking bench for the flash access guard block.
`timescale 1ns/100ps
module fas_top_tb;
    logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [3:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, reset_vector = 0, q;
    logic processor_mode_pin = 1, erase_program_strap_n = 0, chip_enable_pin = 1;
    logic boot_strap_low_pin = 0, boot_strap_high_pin = 0, parallel_mode_pin = 0;
    logic wait_mode = 0, stop_mode = 0, flash_ready_flag = 1, id_restart = 0, id_byte_valid, go = 0;
    logic [55:0] stored_id = 56'h13579BDF2468AC, code = 0;
    logic [7:0] id_byte;
    logic prog_cmd_enable, flash_power_on, flash_access_en, flash_ctrl_init, map_user_area;
    logic user_area_prog_en, boot_area_prog_en, boot_mode;
    logic [2:0] rewrite_mode;
    int n_fail = 0, check_count = 0, n_init = 0, k;

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (flash_ctrl_init === 1'b1) n_init <= n_init + 1;

    fas_top u_fas_top (.*);
    fas_prog_model u_fas_prog_model (.core_clk(core_clk), .go(go), .code(code), .id_byte_valid(id_byte_valid),
        .id_byte(id_byte));

    task w(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task stop_test;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input [31:0] g, input [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // The request is held until waitrequest is sampled low; a hung slave ends the run.
    task bus(input logic wr, input [3:0] a, input [31:0] d, output [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            stop_test();
        end
        r = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge core_clk);
    endtask

    task rst(input logic pm, input logic ep, input logic ce, input logic lo, input logic hi, input logic par);
        processor_mode_pin <= pm;
        erase_program_strap_n <= ep;
        chip_enable_pin <= ce;
        boot_strap_low_pin <= lo;
        boot_strap_high_pin <= hi;
        parallel_mode_pin <= par;
        sys_rst <= 1'h1;
        w(16);
        sys_rst <= 1'h0;
        w(8);
    endtask

    task send(input [55:0] c);
        code <= c;
        go <= 1'h1;
        @(posedge core_clk);
        go <= 1'h0;
        w(11);
    endtask

    initial begin
        rst(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        chk(boot_mode, 1'h1);
        chk(rewrite_mode, 3'h3);
        chk(map_user_area, 1'h0);
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q & 32'hF, 32'h7);
        bus(1'h1, 4'h4, 32'h2, q);
        w(3);
        chk(rewrite_mode, 3'h4);
        bus(1'h1, 4'h4, 32'h0, q);
        $display("test boot straps done");
        send(stored_id ^ 56'h01000000000000);
        chk(prog_cmd_enable, 1'h0);
        bus(1'h0, 4'h8, 32'h0, q);
        chk({q[9], q[6:4]}, 4'h8);
        id_restart <= 1'h1;
        @(posedge core_clk);
        id_restart <= 1'h0;
        send(stored_id);
        chk(prog_cmd_enable, 1'h1);
        bus(1'h1, 4'hC, 32'h1, q);
        w(3);
        chk(prog_cmd_enable, 1'h0);
        send(56'h0);
        chk(prog_cmd_enable, 1'h0);
        bus(1'h0, 4'h8, 32'h0, q);
        chk({q[9], q[4]}, 2'h2);
        reset_vector <= 32'hFFFFFFFF;
        w(3);
        chk(prog_cmd_enable, 1'h1);
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q[5], 1'h1);
        reset_vector <= 32'h0;
        $display("test id check done");
        bus(1'h1, 4'h0, 32'h8, q);
        w(3);
        chk(n_init, 0);
        chk(flash_access_en, 1'h1);
        chk(flash_power_on, 1'h1);
        bus(1'h1, 4'h0, 32'h2, q);
        bus(1'h1, 4'h0, 32'hA, q);
        w(3);
        chk(n_init, 1);
        chk(flash_access_en, 1'h0);
        chk(flash_power_on, 1'h0);
        bus(1'h1, 4'h0, 32'h2, q);
        w(3);
        chk(flash_access_en, 1'h1);
        bus(1'h1, 4'h0, 32'h0, q);
        for (k = 0; k < 2; k++) begin
            wait_mode <= (k == 0);
            stop_mode <= (k == 1);
            w(4);
            chk(flash_power_on, 1'h0);
            wait_mode <= 1'h0;
            stop_mode <= 1'h0;
            w(4);
            chk(flash_power_on, 1'h1);
        end
        $display("test halt and sleep done");
        bus(1'h1, 4'h0, 32'h20, q);
        w(3);
        chk(map_user_area, 1'h1);
        bus(1'h1, 4'h0, 32'h0, q);
        w(3);
        chk(map_user_area, 1'h1);
        chk(rewrite_mode inside {3'h3, 3'h4}, 1'h0);
        bus(1'h0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        bus(1'h0, 4'h0, 32'h0, q);
        chk(q[0], 1'h1);
        flash_ready_flag <= 1'h0;
        bus(1'h0, 4'h0, 32'h0, q);
        chk(q[0], 1'h0);
        flash_ready_flag <= 1'h1;
        $display("test user area done");
        rst(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(boot_mode, 1'h0);
        chk(map_user_area, 1'h1);
        chk(prog_cmd_enable, 1'h1);
        send(stored_id);
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q[9], 1'h0);
        bus(1'h1, 4'h0, 32'h2, q);
        w(3);
        chk(rewrite_mode, 3'h1);
        chk(user_area_prog_en, 1'h1);
        chk(boot_area_prog_en, 1'h0);
        bus(1'h1, 4'h4, 32'h1, q);
        w(3);
        chk(rewrite_mode, 3'h2);
        rst(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
        chk(boot_mode, 1'h1);
        rst(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chk(boot_mode, 1'h0);
        chk(rewrite_mode, 3'h0);
        rst(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
        chk(rewrite_mode, 3'h5);
        chk(boot_area_prog_en, 1'h1);
        chk(user_area_prog_en, 1'h1);
        $display("test rewrite modes done");
        stop_test();
    end
endmodule // fas_top_tb
